// ===== core/gpew_pkg.sv
package gpew_pkg;

  // Pin numbering used throughout the block:
  // 0 port2 line1, 1 port2 line2, 2 port2 line7, 3 port3 line2, 4 port3 line3,
  // 5 port4 line2, 6..13 port5 lines 0..7, 14..21 port6 lines 0..7.
  localparam int NPIN = 22;
  localparam int NEE  = 4;
  localparam int NPORT = 5;

  localparam int DIR_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int DRV_BIT = 7;

  // Direction input, no inversion, open-drain driver.
  localparam logic [7:0] CTRL_RST = 8'h81;

  // Register indices; the byte address is four times the index.
  localparam logic [6:0] CTRL_IDX [NPIN] = '{
    7'h1A, 7'h1B, 7'h20, 7'h25, 7'h26, 7'h3D,
    7'h3F, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46,
    7'h47, 7'h48, 7'h54, 7'h55, 7'h56, 7'h57, 7'h58, 7'h59};
  localparam logic [2:0] PIN_PORT [NPIN] = '{
    3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2,
    3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
  localparam logic [2:0] PIN_LINE [NPIN] = '{
    3'h1, 3'h2, 3'h7, 3'h2, 3'h3, 3'h2,
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7,
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [6:0] DATA_IDX [NPORT] = '{7'h4B, 7'h4C, 7'h4E, 7'h4F, 7'h50};

  localparam logic [6:0] WS1_IDX = 7'h60;
  localparam logic [6:0] WS3_IDX = 7'h61;
  localparam logic [6:0] WS5_IDX = 7'h62;
  localparam logic [6:0] WS6_IDX = 7'h63;
  localparam logic [6:0] MS3_IDX = 7'h64;
  localparam logic [6:0] MS4_IDX = 7'h65;
  localparam logic [6:0] WE3_IDX = 7'h69;
  localparam logic [6:0] WE5_IDX = 7'h6A;
  localparam logic [6:0] WE6_IDX = 7'h6B;
  localparam logic [6:0] ME3_IDX = 7'h6C;
  localparam logic [6:0] ME4_IDX = 7'h6D;
  localparam logic [6:0] SUM_IDX = 7'h6E;
  localparam logic [6:0] EEM_IDX = 7'h6F;

  // Pins able to run in either-edge mode.
  localparam logic [NPIN-1:0] EE_MASK = 22'h00C003;
  // The alternate management interrupt output takes its polarity and driver from this pin.
  localparam int MGMT_CFG_PIN = 2;

  function automatic int ee_slot(input int p);
    case (p)
      1:       ee_slot = 1;
      14:      ee_slot = 2;
      15:      ee_slot = 3;
      default: ee_slot = 0;
    endcase
  endfunction

  typedef struct packed {
    logic [NPIN-1:0][7:0] ctrl;
    logic [NPIN-1:0]      dout;
    logic [NEE-1:0]       either_edge_mode;
    logic [NEE-1:0]       ws1;
    logic [4:0]           ws3;
    logic [7:0]           ws5;
    logic [1:0]           ws6;
    logic [4:0]           we3;
    logic [7:0]           we5;
    logic [1:0]           we6;
    logic [6:0]           ms3;
    logic [3:0]           ms4;
    logic [6:0]           me3;
    logic [3:0]           me4;
    logic [NEE-1:0]       sum;
    logic                 ack;
    logic [31:0]          rdat;
    logic [NPIN-1:0]      pin_o;
    logic [NPIN-1:0]      pin_oe_n;
    logic                 wake;
    logic                 mgmt_o;
    logic                 mgmt_oe_n;
  } gpew_state_t;

  localparam gpew_state_t GPEW_RST = '{
    ctrl:      {NPIN{CTRL_RST}},
    pin_oe_n:  {NPIN{1'b1}},
    mgmt_o:    1'b1,
    mgmt_oe_n: 1'b1,
    default:   '0};

endpackage

// ===== core/gpew_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gpew_sync
  import gpew_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [NPIN-1:0] pin_i,
  output logic      [NPIN-1:0] lvl_o,
  output logic      [NPIN-1:0] rise_o,
  output logic      [NPIN-1:0] fall_o
);

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
  } gpew_sync_t;

  gpew_sync_t r;
  gpew_sync_t r_nxt;

  always_comb
  begin
    r_nxt    = r;
    r_nxt.s1 = pin_i;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  // Edges come from two consecutive synchronised samples only.
  assign lvl_o  = r.s2;
  assign rise_o = r.s2 & ~r.s3;
  assign fall_o = ~r.s2 & r.s3;

endmodule

`default_nettype wire

// ===== core/gpew_top.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module gpew_top
  import gpew_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [8:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [NPIN-1:0] gpio_i,
  output logic      [NPIN-1:0] gpio_o,
  output logic      [NPIN-1:0] gpio_oe_n_o,
  output logic                 wake_req_o,
  output logic                 mgmt_int_output_o,
  output logic                 mgmt_int_output_oe_n_o
);

  gpew_state_t r;
  gpew_state_t r_nxt;

  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic [NPIN-1:0] val;
  logic [NPIN-1:0] as_in;
  logic [NPIN-1:0] ev;
  logic [NPIN-1:0] any_edge;
  logic [NPIN-1:0] gate;
  logic [NPIN-1:0] dval;
  logic [NPIN-1:0] drive;

  logic            req;
  logic            wr;
  logic [6:0]      idx;
  logic [7:0]      wd;
  logic [7:0]      rd;
  logic            wake_any;
  logic            mgmt_any;
  logic            mgmt_val;
  logic [7:0]      ws1_n;
  logic [7:0]      ws3_n;
  logic [7:0]      ws6_n;
  logic [7:0]      ms3_n;
  logic [7:0]      ms4_n;
  logic [7:0]      sum_n;

  gpew_sync u_sync
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (gpio_i),
    .lvl_o  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  // Assembles one port's data register view from the per-pin state.
  function automatic logic [7:0] port_byte(
    input logic [2:0]      p,
    input logic [NPIN-1:0] v,
    input logic [NPIN-1:0] in_mode,
    input logic [NPIN-1:0] d
  );
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < NPIN; i++)
    begin
      if (PIN_PORT[i] == p)
      begin
        b[PIN_LINE[i]] = in_mode[i] ? v[i] : d[i];
      end
    end
    return b;
  endfunction

  // Write-one-to-clear with the hardware set taking priority.
  function automatic logic [7:0] w1c(
    input logic [7:0] st,
    input logic [7:0] set,
    input logic       hit,
    input logic [7:0] d
  );
    logic [7:0] clr;
    clr = hit ? d : 8'h00;
    return (st & ~clr) | set;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      localparam int SLOT = ee_slot(gi);
      logic mode_on;
      logic pol;
      logic od;

      assign mode_on      = EE_MASK[gi] & r.either_edge_mode[SLOT];
      assign pol          = r.ctrl[gi][POL_BIT];
      assign od           = r.ctrl[gi][DRV_BIT];
      assign val[gi]      = lvl[gi] ^ pol;
      assign as_in[gi]    = r.ctrl[gi][DIR_BIT] | mode_on;
      assign any_edge[gi] = rise[gi] | fall[gi];
      // Either-edge mode takes any transition; otherwise only inputs see the polarity edge.
      assign ev[gi]       = mode_on ? any_edge[gi]
                                    : (r.ctrl[gi][DIR_BIT] & (pol ? fall[gi] : rise[gi]));
      assign gate[gi]     = ~EE_MASK[gi] | mode_on;
      assign dval[gi]     = r.dout[gi] ^ pol;
      // Open drain only sinks; a high level releases the pin.
      assign drive[gi]    = ~as_in[gi] & (~od | ~dval[gi]);
    end
  endgenerate

  always_comb
  begin
    r_nxt = r;
    req   = wb_cyc_i & wb_stb_i & ~r.ack;
    wr    = req & wb_we_i & wb_sel_i[0];
    idx   = wb_adr_i[8:2];
    wd    = wb_dat_i[7:0];
    rd    = 8'h00;

    // Register read view; unmapped indices read zero.
    for (int i = 0; i < NPIN; i++)
    begin
      if (idx == CTRL_IDX[i])
      begin
        rd = r.ctrl[i];
      end
    end
    for (int p = 0; p < NPORT; p++)
    begin
      if (idx == DATA_IDX[p])
      begin
        rd = port_byte(p[2:0], val, as_in, r.dout);
      end
    end
    case (idx)
      WS1_IDX: rd = {val[15], val[14], val[1], val[0], r.ws1};
      WS3_IDX: rd = {3'h0, r.ws3};
      WS5_IDX: rd = r.ws5;
      WS6_IDX: rd = {6'h00, r.ws6};
      MS3_IDX: rd = {1'b0, r.ms3};
      MS4_IDX: rd = {4'h0, r.ms4};
      WE3_IDX: rd = {3'h0, r.we3};
      WE5_IDX: rd = r.we5;
      WE6_IDX: rd = {6'h00, r.we6};
      ME3_IDX: rd = {1'b0, r.me3};
      ME4_IDX: rd = {4'h0, r.me4};
      SUM_IDX: rd = {4'h0, r.sum};
      EEM_IDX: rd = {4'h0, r.either_edge_mode};
      default: rd = rd;
    endcase

    r_nxt.ack = req;
    // Read data holds the last read value, so writes leave it alone.
    if (req && !wb_we_i)
    begin
      r_nxt.rdat = {24'h000000, rd};
    end

    // Control and data writes.
    for (int i = 0; i < NPIN; i++)
    begin
      if (wr && idx == CTRL_IDX[i])
      begin
        r_nxt.ctrl[i] = wd;
      end
      if (wr && idx == DATA_IDX[PIN_PORT[i]] && !as_in[i])
      begin
        r_nxt.dout[i] = wd[PIN_LINE[i]];
      end
    end
    if (wr && idx == WE3_IDX)
    begin
      r_nxt.we3 = wd[4:0];
    end
    if (wr && idx == WE5_IDX)
    begin
      r_nxt.we5 = wd;
    end
    if (wr && idx == WE6_IDX)
    begin
      r_nxt.we6 = wd[1:0];
    end
    if (wr && idx == ME3_IDX)
    begin
      r_nxt.me3 = wd[6:0];
    end
    if (wr && idx == ME4_IDX)
    begin
      r_nxt.me4 = wd[3:0];
    end
    if (wr && idx == EEM_IDX)
    begin
      r_nxt.either_edge_mode = wd[3:0];
    end

    // Sticky status, set on events whatever the enables say.
    ws1_n     = w1c({4'h0, r.ws1}, {4'h0, any_edge[15], any_edge[14], any_edge[1], any_edge[0]},
                    wr && idx == WS1_IDX, wd);
    r_nxt.ws1 = ws1_n[3:0];
    ws3_n     = w1c({3'h0, r.ws3}, {3'h0, ev[4:0]}, wr && idx == WS3_IDX, wd);
    r_nxt.ws3 = ws3_n[4:0];
    r_nxt.ws5 = w1c(r.ws5, ev[13:6], wr && idx == WS5_IDX, wd);
    ws6_n     = w1c({6'h00, r.ws6}, {6'h00, ev[15:14]}, wr && idx == WS6_IDX, wd);
    r_nxt.ws6 = ws6_n[1:0];
    ms3_n     = w1c({1'b0, r.ms3}, {1'b0, ev[14], ev[13:10], ev[1:0]},
                    wr && idx == MS3_IDX, wd);
    r_nxt.ms3 = ms3_n[6:0];
    ms4_n     = w1c({4'h0, r.ms4}, {4'h0, ev[15], ev[5:3]}, wr && idx == MS4_IDX, wd);
    r_nxt.ms4 = ms4_n[3:0];
    sum_n     = w1c({4'h0, r.sum}, {4'h0, any_edge[15], any_edge[14], any_edge[1], any_edge[0]},
                    wr && idx == SUM_IDX, wd);
    r_nxt.sum = sum_n[3:0];

    // Requests: status and enable, with either-edge pins also needing their mode.
    wake_any = |(r.ws3 & r.we3 & gate[4:0])
             | |(r.ws5 & r.we5 & gate[13:6])
             | |(r.ws6 & r.we6 & gate[15:14]);
    mgmt_any = |(r.ms3 & r.me3 & {gate[14], gate[13:10], gate[1:0]})
             | |(r.ms4 & r.me4 & {gate[15], gate[5:3]});
    r_nxt.wake = wake_any;

    // Active low unless inverted; open drain releases the pin whenever the output is high.
    mgmt_val        = r.ctrl[MGMT_CFG_PIN][POL_BIT] ? mgmt_any : ~mgmt_any;
    r_nxt.mgmt_o    = mgmt_val;
    r_nxt.mgmt_oe_n = r.ctrl[MGMT_CFG_PIN][DRV_BIT] & mgmt_val;

    r_nxt.pin_o    = dval;
    r_nxt.pin_oe_n = ~drive;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= GPEW_RST;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  assign wb_dat_o               = r.rdat;
  assign wb_ack_o               = r.ack;
  assign gpio_o                 = r.pin_o;
  assign gpio_oe_n_o            = r.pin_oe_n;
  assign wake_req_o             = r.wake;
  assign mgmt_int_output_o      = r.mgmt_o;
  assign mgmt_int_output_oe_n_o = r.mgmt_oe_n;

endmodule

`default_nettype wire

// ===== dv/gpew_props.sv
`timescale 1ns/1ps
`default_nettype none
module gpew_props
  import gpew_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [NPIN-1:0] gpio_o,
  input wire logic [NPIN-1:0] gpio_oe_n_o,
  input wire logic            wake_req_o
);
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_gap;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_follows: assert property (s_req |=> s_ack_gap)
    else $error("No single ack after a request.");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("Ack without a request.");
  a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("Read data above the byte lane.");
  a_dat_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("Read data changed outside a read.");
  a_oe_hold: assert property (!$past(wr) |-> $stable(gpio_oe_n_o))
    else $error("Enable changed without a write.");
  a_out_hold: assert property (!$past(wr) |-> $stable(gpio_o))
    else $error("Drive value changed without a write.");
  a_wake_fall: assert property ($fell(wake_req_o) |-> $past(wr) || $past(wr, 2))
    else $error("Wake request dropped without a write.");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Ack while idle.");
endmodule
`default_nettype wire

// ===== dv/gpew_pins.sv
`timescale 1ns/1ps
`default_nettype none
module gpew_pins
  import gpew_pkg::*;
(
  input  wire logic [NPIN-1:0] ext_i,
  input  wire logic [NPIN-1:0] drv_i,
  input  wire logic [NPIN-1:0] oe_n_i,
  output logic      [NPIN-1:0] pin_o
);
  // A wire shows the device's drive where enabled, else the external source.
  assign pin_o = (oe_n_i & ext_i) | (~oe_n_i & drv_i);
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import gpew_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            cyc = 1'b0;
  logic            stb = 1'b0;
  logic            we = 1'b0;
  logic [8:0]      adr = 9'h000;
  logic [31:0]     wdat = 32'h00000000;
  logic [31:0]     rdat;
  logic            ack;
  logic [NPIN-1:0] ext = '0;
  logic [NPIN-1:0] pin;
  logic [NPIN-1:0] gp_o;
  logic [NPIN-1:0] gp_oe_n;
  logic            wake;
  logic            mgmt;
  logic            mgmt_oe_n;
  logic [7:0]      rd;
  int              n_mismatch = 0;
  int              n_compared = 0;

  always #10 clk_i = ~clk_i;

  gpew_pins u_pins (.ext_i(ext), .drv_i(gp_o), .oe_n_i(gp_oe_n), .pin_o(pin));

  gpew_top u_dut (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .wb_cyc_i               (cyc),
    .wb_stb_i               (stb),
    .wb_we_i                (we),
    .wb_adr_i               (adr),
    .wb_sel_i               (4'h1),
    .wb_dat_i               (wdat),
    .wb_dat_o               (rdat),
    .wb_ack_o               (ack),
    .gpio_i                 (pin),
    .gpio_o                 (gp_o),
    .gpio_oe_n_o            (gp_oe_n),
    .wake_req_o             (wake),
    .mgmt_int_output_o      (mgmt),
    .mgmt_int_output_oe_n_o (mgmt_oe_n)
  );

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    rd = rdat[7:0];
    if (k >= 50)
      n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk({24'h000000, rd}, {24'h000000, exp});
  endtask

  task automatic t_reset();
    rdc(7'h47, 8'h81);
    rdc(7'h59, 8'h81);
    bus(1'b1, 7'h7F, 8'hFF);
    rdc(7'h7F, 8'h00);
    chk(32'(gp_oe_n), 32'h003FFFFF);
    chk({30'h0, mgmt, mgmt_oe_n}, 32'h3);
  endtask

  task automatic t_output();
    bus(1'b1, 7'h54, 8'h00);
    bus(1'b1, 7'h50, 8'h04);
    repeat (2) @(posedge clk_i);
    chk(32'(gp_oe_n[16]), 32'h0);
    chk(32'(pin[16]), 32'h1);
    bus(1'b1, 7'h54, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(32'(pin[16]), 32'h0);
    rdc(7'h50, 8'h04);
  endtask

  task automatic t_input();
    ext[17] <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc(7'h50, 8'h0C);
    bus(1'b1, 7'h50, 8'h04);
    rdc(7'h50, 8'h0C);
    chk(32'(gp_oe_n[17]), 32'h1);
    bus(1'b1, 7'h55, 8'h83);
    rdc(7'h50, 8'h04);
  endtask

  task automatic t_wake();
    bus(1'b1, 7'h6A, 8'h01);
    ext[6] <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(7'h62, 8'h01);
    chk(32'(wake), 32'h1);
    bus(1'b1, 7'h62, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(32'(wake), 32'h0);
    ext[6] <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdc(7'h62, 8'h00);
    bus(1'b1, 7'h3F, 8'h83);
    ext[6] <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(7'h62, 8'h00);
    ext[6] <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdc(7'h62, 8'h01);
  endtask

  task automatic t_outdir();
    bus(1'b1, 7'h62, 8'hFF);
    bus(1'b1, 7'h40, 8'h00);
    bus(1'b1, 7'h4F, 8'h02);
    repeat (6) @(posedge clk_i);
    chk(32'(pin[7]), 32'h1);
    rdc(7'h62, 8'h00);
  endtask

  task automatic t_either();
    bus(1'b1, 7'h1A, 8'h00);
    bus(1'b1, 7'h6F, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(32'(gp_oe_n[0]), 32'h1);
    ext[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(7'h6E, 8'h01);
    rdc(7'h60, 8'h11);
    rdc(7'h61, 8'h01);
    bus(1'b1, 7'h6E, 8'h01);
    ext[0] <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdc(7'h6E, 8'h01);
    rdc(7'h60, 8'h01);
  endtask

  // The either-edge pin's management status drives the active-low open-drain output.
  task automatic t_mgmt();
    rdc(7'h64, 8'h01);
    bus(1'b1, 7'h6C, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({30'h0, mgmt, mgmt_oe_n}, 32'h0);
    bus(1'b1, 7'h64, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({30'h0, mgmt, mgmt_oe_n}, 32'h3);
  endtask

  initial
  begin
    #100us;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_output();
    t_input();
    t_wake();
    t_outdir();
    t_either();
    t_mgmt();
    conclude();
  end
endmodule

bind gpew_top gpew_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gpio_o(gpio_o),
  .gpio_oe_n_o(gpio_oe_n_o), .wake_req_o(wake_req_o)
);
`default_nettype wire
